// File: logic/relay_diag_pkg.sv
/*
 Shared constants for the relay driver diagnosis bank: frame fields,
 register addresses, bit positions and protection timing.
 Assumes a 50 MHz system clock.
*/
package relay_diag_pkg;
    localparam int CLK_MHZ = 50;
    localparam int CHANNELS = 8;
    // Overload shutdown is a longest time: cycles round down
    localparam int OVL_DELAY_US = 60;
    localparam int OVL_CYCLES = (OVL_DELAY_US * CLK_MHZ) < 1 ? 1 : OVL_DELAY_US * CLK_MHZ;
    // Open-load filter: the least figure of its window, rounded up
    localparam int OL_DELAY_US = 100;
    localparam int OL_CYCLES = (OL_DELAY_US * CLK_MHZ) < 1 ? 1 : OL_DELAY_US * CLK_MHZ;
    localparam int CNT_W = 13;
    // Frame fields
    localparam int FRM_WRITE = 7;
    localparam int FRM_ADDR_HI = 6;
    localparam int FRM_ADDR_LO = 4;
    localparam int FRM_STD = 1;
    localparam int FRM_BANK = 0;
    localparam int FRM_DIAG_MARK = 6;
    localparam logic [2:0] ADDR_CMD = 3'h6;
    // Command register fields
    localparam int CMD_CLEAR = 0;
    localparam int CMD_RST = 1;
    localparam int CMD_STANDBY = 2;
    localparam int CMD_WAKE = 3;
    localparam logic [3:0] CMD_RESET = 4'h0;
    // Answer selected for the next frame
    typedef enum logic [1:0] {
        RESP_STD = 2'b00,
        RESP_DIAG = 2'b01,
        RESP_CTRL = 2'b10
    } resp_t;
endpackage

// File: logic/spi_link_shifter.sv
/*
 Serial shifter on the link clock: samples the serial input on the
 falling clock edge, drives the serial output on the rising edge.
 Assumes the clock is low at every chip select transition and
 that the answer word stays stable while chip select is low.
*/
`timescale 1ns/100ps
module spi_link_shifter (
    // Link side
    input wire logic sclk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    // System side
    input wire logic [7:0] tx_word,
    output logic [7:0] rx_byte,
    output logic [2:0] bit_cnt,
    output logic frame_tog
);
    logic rx_fresh;
    logic tx_fresh;
    logic [7:0] tx_sh;

    // Chip select high marks the next edge as the first of a frame
    always_ff @(negedge sclk or posedge cs_n or negedge reset_n) begin
        if (!reset_n) begin
            rx_fresh <= 1'b1;
        end else if (cs_n) begin
            rx_fresh <= 1'b1;
        end else begin
            rx_fresh <= 1'b0;
        end
    end

    always_ff @(posedge sclk or posedge cs_n or negedge reset_n) begin
        if (!reset_n) begin
            tx_fresh <= 1'b1;
        end else if (cs_n) begin
            tx_fresh <= 1'b1;
        end else begin
            tx_fresh <= 1'b0;
        end
    end

    // Count and toggle survive chip select rising; the clock is then still
    always_ff @(negedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_byte <= 8'h00;
            bit_cnt <= 3'h0;
            frame_tog <= 1'b0;
        end else begin
            rx_byte <= {rx_byte[6:0], si};
            bit_cnt <= rx_fresh ? 3'h1 : bit_cnt + 3'h1;
            if (rx_fresh) begin
                frame_tog <= ~frame_tog;
            end
        end
    end

    // Received bits follow the answer so that chained parts see them
    always_ff @(posedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            so <= 1'b0;
            tx_sh <= 8'h00;
        end else if (tx_fresh) begin
            so <= tx_word[7];
            tx_sh <= {tx_word[6:0], 1'b0};
        end else begin
            so <= tx_sh[7];
            tx_sh <= {tx_sh[6:0], rx_byte[0]};
        end
    end
endmodule // spi_link_shifter

// File: logic/channel_guard.sv
/*
 Protection and diagnosis of one output channel: overload timer,
 over-temperature, open-load filter, latched flags and the enable.
 Assumes sensor inputs are asynchronous pins.
*/
`timescale 1ns/100ps
module channel_guard
    import relay_diag_pkg::*;
#(
    parameter int OVL_LIMIT = OVL_CYCLES,
    parameter int OL_LIMIT = OL_CYCLES,
    parameter int W = CNT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Sensors and request
    input wire logic on_request,
    input wire logic overload_pin,
    input wire logic overtemp_pin,
    input wire logic open_load_pin,
    // Flag control
    input wire logic fault_clear,
    input wire logic ol_clear,
    // State
    output logic fault_flag,
    output logic open_load_flag,
    output logic enable
);
    logic [2:0] meta;
    logic [2:0] sens;
    logic [W-1:0] ovl_cnt;
    logic [W-1:0] ol_cnt;
    logic ovl_run;
    logic ol_run;
    logic ovl_hit;
    logic ol_hit;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= 3'h0;
            sens <= 3'h0;
        end else begin
            meta <= {open_load_pin, overtemp_pin, overload_pin};
            sens <= meta;
        end
    end

    assign ovl_run = sens[0] && enable;
    assign ovl_hit = ovl_run && ovl_cnt == W'(OVL_LIMIT - 1); // [R9]
    // No open-load watch while the channel is on
    assign ol_run = sens[2] && !enable; // [R5]
    assign ol_hit = ol_run && ol_cnt == W'(OL_LIMIT - 1); // [R6]

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ovl_cnt <= '0;
        end else if (ovl_run && !ovl_hit) begin
            ovl_cnt <= ovl_cnt + W'(1);
        end else begin
            ovl_cnt <= '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ol_cnt <= '0;
        end else if (ol_run && !ol_hit) begin
            ol_cnt <= ol_cnt + W'(1);
        end else begin
            ol_cnt <= '0;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_flag <= 1'b0;
        end else if (ovl_hit || sens[1]) begin
            fault_flag <= 1'b1; // [R1] [R8] [R9] [R14]
        end else if (fault_clear) begin
            fault_flag <= 1'b0; // [R2]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            open_load_flag <= 1'b0;
        end else if (ol_hit) begin
            open_load_flag <= 1'b1; // [R4] [R6]
        end else if (ol_clear) begin
            open_load_flag <= 1'b0; // [R4]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enable <= 1'b0;
        end else begin
            enable <= on_request && !fault_flag && !ovl_hit && !sens[1]; // [R8] [R15]
        end
    end

    AST_FAULT_HOLD: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
        fault_flag && !fault_clear |=> fault_flag)
        else $error("fault flag dropped without clear");
    AST_OVT_OFF: assert property (@(posedge clk) disable iff (!reset_n) // [R8]
        sens[1] |=> fault_flag && !enable)
        else $error("overheated channel not latched off");
    AST_OVL_DELAY: assert property (@(posedge clk) disable iff (!reset_n) // [R9]
        $rose(fault_flag) && !$past(sens[1]) |-> $past(ovl_cnt) == W'(OVL_LIMIT - 1))
        else $error("overload shutdown at wrong time");
    AST_OL_FILTER: assert property (@(posedge clk) disable iff (!reset_n) // [R6]
        $rose(open_load_flag) |-> $past(ol_cnt) == W'(OL_LIMIT - 1) && !$past(enable))
        else $error("open load set without full filter");
endmodule // channel_guard

// File: logic/relay_diag_bank.sv
/*
 Diagnosis and command register bank of an eight-channel relay driver
 behind an SPI slave: latched fault and open-load flags, four read-only
 diagnosis registers, and the command register with its self-clearing
 protection latch clear.
 Assumes the SPI master keeps the serial clock low at chip select
 edges and leaves at least 60 ns from chip select falling to the
 first rising serial clock edge.
 Sensor pins are taken as asynchronous; channel requests share clk.
*/
// Overview of operation
// R1: Each channel's protection fault stays latched after the fault goes away.
// R2: Writing 1 to the clear bit of the command register clears all faults.
// R3: The clear bit returns to 0 after the next valid frame.
// R4: Open-load flags latch per channel and clear on reading their register.
// R5: No open-load detection while a channel is on.
// R6: An off channel sets open-load after the comparator holds the filter delay.
// R7: The host enables off-state diagnosis current per channel over SPI. This bank has no register bit or output for it.
// R8: Over-temperature sets the fault flag and switches the channel off.
// R9: Overload switches the channel off within 60 us and sets its fault.
// R10: Diagnosis registers are read-only, read with bank select 1.
// R11: Fault flags sit at bits 2 and 0 for odd and even channel.
// R12: Open-load flags sit at bits 3 and 1 for odd and even channel.
// R13: Command register at address 110 holds clear, soft reset, standby, wake.
// R14: Over-temperature also sets the fault flag while the channel is off.
// R15: A shut-down channel stays off until the host clears the latch.
// R16: Read-to-clear acts only when a valid frame returned the contents.
`timescale 1ns/100ps
module relay_diag_bank
    import relay_diag_pkg::*;
#(
    parameter int OL_FILTER_CYCLES = OL_CYCLES,
    parameter int OVL_SHUTDOWN_CYCLES = OVL_CYCLES
) (
    // System clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // SPI link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    // Channel requests from the input matrix
    input wire logic [CHANNELS-1:0] on_request,
    // Sensor pins
    input wire logic [CHANNELS-1:0] overload_pin,
    input wire logic [CHANNELS-1:0] overtemp_pin,
    input wire logic [CHANNELS-1:0] open_load_pin,
    // Power stage control
    output logic [CHANNELS-1:0] ch_enable,
    // Command register bits toward power management
    output logic soft_reset_bit,
    output logic standby_bit,
    output logic wake_bit
);
    logic [7:0] rx_byte;
    logic [2:0] bit_cnt;
    logic frame_tog;
    logic [7:0] tx_word;
    logic [7:0] next_tx;
    logic cs_meta;
    logic cs_s;
    logic cs_d;
    logic tog_meta;
    logic tog_s;
    logic tog_seen;
    logic cs_rise;
    logic frame_ok;
    logic is_write;
    logic is_cmd_write;
    logic is_bank_read;
    logic [2:0] frame_addr;
    logic [3:0] frame_data;
    logic [3:0] cmd;
    logic fault_clear;
    logic [CHANNELS-1:0] ol_clear;
    logic [CHANNELS-1:0] next_ol_clear;
    logic [CHANNELS-1:0] fault_flag;
    logic [CHANNELS-1:0] open_load_flag;
    logic [3:0] pair_fault;
    resp_t sel_kind;
    logic [2:0] sel_addr;

    spi_link_shifter u_link (
        .sclk(sclk),
        .reset_n(reset_n),
        .cs_n(cs_n),
        .si(si),
        .so(so),
        .tx_word(tx_word),
        .rx_byte(rx_byte),
        .bit_cnt(bit_cnt),
        .frame_tog(frame_tog)
    );

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
        channel_guard #(
            .OVL_LIMIT(OVL_SHUTDOWN_CYCLES),
            .OL_LIMIT(OL_FILTER_CYCLES),
            .W(CNT_W)
        ) u_guard (
            .clk(clk),
            .reset_n(reset_n),
            .on_request(on_request[ch]),
            .overload_pin(overload_pin[ch]),
            .overtemp_pin(overtemp_pin[ch]),
            .open_load_pin(open_load_pin[ch]),
            .fault_clear(fault_clear),
            .ol_clear(ol_clear[ch]),
            .fault_flag(fault_flag[ch]),
            .open_load_flag(open_load_flag[ch]),
            .enable(ch_enable[ch])
        );
    end

    // Chip select and frame toggle cross into the system clock
    // Idle-level reset values keep a false edge from following reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_meta <= 1'b1;
            cs_s <= 1'b1;
            cs_d <= 1'b1;
        end else begin
            cs_meta <= cs_n;
            cs_s <= cs_meta;
            cs_d <= cs_s;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tog_meta <= 1'b0;
            tog_s <= 1'b0;
        end else begin
            tog_meta <= frame_tog;
            tog_s <= tog_meta;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tog_seen <= 1'b0;
        end else if (cs_rise) begin
            tog_seen <= tog_s;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            so_oe <= 1'b0;
        end else begin
            so_oe <= !cs_s;
        end
    end

    assign cs_rise = cs_s && !cs_d;

    // Count and byte are read across domains only here: the serial clock
    // is still once chip select is high, so they cannot be moving.
    // A frame without a single clock leaves the toggle alone and is void.
    assign frame_ok = cs_rise && tog_s != tog_seen && bit_cnt == 3'h0;

    assign is_write = rx_byte[FRM_WRITE];
    assign frame_addr = rx_byte[FRM_ADDR_HI:FRM_ADDR_LO];
    assign frame_data = rx_byte[3:0];
    // Only the command register of the control bank lives here
    assign is_cmd_write = is_write && frame_addr == ADDR_CMD; // [R10] [R13]
    assign is_bank_read = !is_write && !rx_byte[FRM_STD];

    // Command register; the clear bit falls back after a valid frame
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd <= CMD_RESET;
        end else if (frame_ok) begin
            if (is_cmd_write) begin
                cmd <= frame_data; // [R13]
            end else begin
                cmd[CMD_CLEAR] <= 1'b0; // [R3]
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_clear <= 1'b0;
        end else begin
            // One cycle wide; a flag set in that cycle keeps its set
            fault_clear <= frame_ok && is_cmd_write && frame_data[CMD_CLEAR]; // [R2]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            soft_reset_bit <= 1'b0;
            standby_bit <= 1'b0;
            wake_bit <= 1'b0;
        end else begin
            soft_reset_bit <= cmd[CMD_RST];
            standby_bit <= cmd[CMD_STANDBY];
            wake_bit <= cmd[CMD_WAKE];
        end
    end

    // Answer for the next frame, chosen by the frame just ended
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_kind <= RESP_STD;
            sel_addr <= 3'h0;
        end else if (frame_ok) begin
            sel_addr <= frame_addr;
            if (is_bank_read && rx_byte[FRM_BANK]) begin
                sel_kind <= RESP_DIAG; // [R10]
            end else if (is_bank_read) begin
                sel_kind <= RESP_CTRL;
            end else begin
                sel_kind <= RESP_STD;
            end
        end
    end

    // Open-load flags of a register clear only once a valid frame
    // has carried that register out; a void frame keeps them.
    always_comb begin
        next_ol_clear = '0;
        if (frame_ok && sel_kind == RESP_DIAG) begin
            next_ol_clear[{sel_addr[1:0], 1'b0}] = 1'b1; // [R4] [R16]
            next_ol_clear[{sel_addr[1:0], 1'b1}] = 1'b1; // [R4] [R16]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ol_clear <= '0;
        end else begin
            ol_clear <= next_ol_clear;
        end
    end

    always_comb begin
        pair_fault = 4'h0;
        for (int p = 0; p < CHANNELS / 2; p++) begin
            pair_fault[p] = fault_flag[2 * p] | fault_flag[2 * p + 1];
        end
    end

    always_comb begin
        next_tx = 8'h00;
        case (sel_kind)
            RESP_DIAG: begin
                next_tx[FRM_DIAG_MARK] = 1'b1;
                next_tx[5:4] = sel_addr[1:0];
                next_tx[3] = open_load_flag[{sel_addr[1:0], 1'b1}]; // [R12]
                next_tx[2] = fault_flag[{sel_addr[1:0], 1'b1}]; // [R11]
                next_tx[1] = open_load_flag[{sel_addr[1:0], 1'b0}]; // [R12]
                next_tx[0] = fault_flag[{sel_addr[1:0], 1'b0}]; // [R11]
            end
            RESP_CTRL: begin
                next_tx[FRM_WRITE] = 1'b1;
                next_tx[FRM_ADDR_HI:FRM_ADDR_LO] = sel_addr;
                if (sel_addr == ADDR_CMD) begin
                    next_tx[3:0] = cmd; // [R13]
                end
            end
            RESP_STD: begin
                next_tx[3:0] = pair_fault;
            end
            default: begin
                next_tx = 8'h00;
            end
        endcase
    end

    // Frozen while chip select is low so the shifter sees a stable word
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_word <= 8'h00;
        end else if (cs_s) begin
            tx_word <= next_tx;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    AST_CLEAR_PULSE: assert property ( // [R2]
        frame_ok && is_cmd_write && frame_data[CMD_CLEAR] |=> fault_clear ##1 (fault_flag == '0
            || $past(overtemp_pin, 3) != '0 || $past(overload_pin, 3) != '0))
        else $error("clear bit write did not clear faults");
    AST_CLEAR_SELF: assert property ( // [R3]
        cmd[CMD_CLEAR] && frame_ok && !is_cmd_write |=> !cmd[CMD_CLEAR])
        else $error("clear bit did not fall back after frame");
    AST_OL_AFTER_FRAME: assert property ( // [R16]
        ol_clear != '0 |-> $past(frame_ok) && $past(sel_kind) == RESP_DIAG)
        else $error("open-load cleared without valid readout");
    AST_OL_OFF_STATE: assert property ( // [R5]
        ($past(ch_enable, 2) & $past(ch_enable) & open_load_flag & ~$past(open_load_flag)) == '0)
        else $error("open load set on an enabled channel");
    AST_OFF_WHILE_FAULT: assert property ( // [R15]
        ($past(fault_flag) & ch_enable) == '0)
        else $error("channel on while fault latched");
    AST_DIAG_RO: assert property ( // [R10]
        frame_ok && is_write && frame_addr != ADDR_CMD |=> $stable(cmd[3:1]))
        else $error("write outside command register changed it");
    AST_DIAG_LAYOUT: assert property ( // [R11] [R12]
        cs_s && sel_kind == RESP_DIAG && sel_addr[1:0] == 2'h0 && $stable(sel_kind)
            |=> tx_word[3:0] == {$past(open_load_flag[1]), $past(fault_flag[1]),
                                 $past(open_load_flag[0]), $past(fault_flag[0])})
        else $error("diagnosis word layout wrong");
    AST_CMD_READ: assert property ( // [R13]
        cs_s && sel_kind == RESP_CTRL && sel_addr == ADDR_CMD |=> tx_word == {1'b1, ADDR_CMD, $past(cmd)})
        else $error("command register readback wrong");

    // Refused frames and idle cycles must leave the command register and the answer selection as they were
    AST_VOID_NO_WRITE: assert property ( // [R13] [R16]
        !frame_ok |=> $stable(cmd))
        else $error("command register changed without a valid frame");
    AST_SEL_HOLD: assert property ( // [R16]
        !frame_ok |=> $stable(sel_kind) && $stable(sel_addr))
        else $error("answer selection changed without a valid frame");
    AST_CLEAR_STAYS: assert property ( // [R3]
        cmd[CMD_CLEAR] && !frame_ok |=> cmd[CMD_CLEAR])
        else $error("clear bit fell without a valid frame");
    AST_CLEAR_SINGLE: assert property ( // [R2]
        fault_clear |=> !fault_clear)
        else $error("fault clear pulse longer than one cycle");
    AST_OUT_BITS: assert property ( // [R13]
        {wake_bit, standby_bit, soft_reset_bit} == $past(cmd[CMD_WAKE:CMD_RST]))
        else $error("command output bits do not follow the register");
    // A word that moved under a running frame would tear the answer
    AST_TX_FROZEN: assert property ( // [R11] [R12]
        !cs_s |=> $stable(tx_word))
        else $error("answer word changed during a frame");
    AST_STD_WORD: assert property ( // [R1]
        cs_s && sel_kind == RESP_STD |=> tx_word == {4'h0, $past(pair_fault)})
        else $error("standard diagnosis word wrong");

    COV_CLEAR_WRITE: cover property (frame_ok && is_cmd_write && frame_data[CMD_CLEAR]);
    COV_DIAG_CLEAR: cover property (ol_clear != '0);
    COV_FAULT: cover property ($rose(fault_flag[0]));
    COV_VOID_FRAME: cover property (cs_rise && !frame_ok && bit_cnt != 3'h0);
    COV_OL_SET: cover property ($rose(open_load_flag[2]));
endmodule // relay_diag_bank

// File: tb/spi_host_model.sv
/*
 SPI master model standing in for the system microcontroller.
 Assumes the bench resolves the SO wire and calls frame() one at a time.
*/
`timescale 1ns/100ps
module spi_host_model (
    // Link pins
    output logic sclk,
    output logic cs_n,
    output logic si,
    // Resolved serial output of the device
    input wire logic so_line
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // Clock is low at every chip select edge and stands still between frames
    // A short bit count makes a refused frame on purpose
    task automatic frame(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        // Off the system clock edge, so chip select never races its synchroniser
        #7;
        cs_n = 1'b0;
        #100;
        for (int i = 0; i < nbits; i++) begin
            si = tx[7 - i];
            #31.2 sclk = 1'b1;
            #62.5 rx = {rx[6:0], so_line};
            sclk = 1'b0;
            #31.3;
        end
        #100 cs_n = 1'b1;
        si = ~si;
        // Gap well above the device's minimum, so the take and flag updates land
        #300;
    endtask
endmodule // spi_host_model

// File: tb/relay_diag_bank_bench.sv
/*
 Self-checking bench for the relay diagnosis bank: frames through the
 SPI host model, sensor pins and requests driven on the system clock.
 Assumes shortened open-load filter and overload shutdown counts.
*/
`timescale 1ns/100ps
module relay_diag_bank_bench;
    import relay_diag_pkg::*;
    localparam int OL_N = 20;
    localparam int OVL_N = 10;
    logic clk, reset_n, sclk, cs_n, si, so, so_oe, so_line;
    logic soft_reset_bit, standby_bit, wake_bit;
    logic [CHANNELS-1:0] on_request, overload_pin, overtemp_pin, open_load_pin, ch_enable;
    logic [7:0] rx;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;

    relay_diag_bank #(.OL_FILTER_CYCLES(OL_N), .OVL_SHUTDOWN_CYCLES(OVL_N)) u_relay_diag_bank (
        .clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
        .on_request(on_request), .overload_pin(overload_pin), .overtemp_pin(overtemp_pin),
        .open_load_pin(open_load_pin), .ch_enable(ch_enable), .soft_reset_bit(soft_reset_bit),
        .standby_bit(standby_bit), .wake_bit(wake_bit));
    spi_host_model u_spi_host_model (.sclk(sclk), .cs_n(cs_n), .si(si), .so_line(so_line));

    // Released SO shows the inverse of its last bit, so a stale bit cannot pass for an answer
    assign so_line = so_oe ? so : ~so;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (miscompares == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wclk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Select a register, then fetch its word with a standard diagnosis read
    task automatic rd(input logic [7:0] sel, input logic [7:0] exp);
        logic [7:0] r;
        u_spi_host_model.frame(sel, 8, r);
        u_spi_host_model.frame(8'h02, 8, r);
        chk(r, exp);
    endtask

    initial begin
        reset_n = 1'b0;
        on_request = '0;
        overload_pin = '0;
        overtemp_pin = '0;
        open_load_pin = '0;
        wclk(5);
        reset_n <= 1'b1;
        wclk(5);
        // Write to a control address outside this bank must not disturb flags
        u_spi_host_model.frame(8'h8f, 8, rx);
        u_spi_host_model.frame(8'hcf, 8, rx);
        rd(8'h01, 8'h40);
        rd(8'h60, 8'he0);
        u_spi_host_model.frame(8'hee, 8, rx);
        chk({5'h00, wake_bit, standby_bit, soft_reset_bit}, 8'h07);
        rd(8'h60, 8'hee);
        u_spi_host_model.frame(8'he0, 8, rx);
        wclk(1);
        on_request <= 8'h23;
        wclk(6);
        chk(ch_enable, 8'h23);
        overload_pin <= 8'h01;
        wclk(OVL_N + 6);
        chk(ch_enable, 8'h22);
        overload_pin <= 8'h00;
        overtemp_pin <= 8'h28;
        wclk(5);
        chk(ch_enable, 8'h02);
        overtemp_pin <= 8'h00;
        wclk(6);
        chk(ch_enable, 8'h02);
        rd(8'h01, 8'h41);
        rd(8'h11, 8'h54);
        rd(8'h21, 8'h64);
        rd(8'h02, 8'h07);
        u_spi_host_model.frame(8'he1, 8, rx);
        rd(8'h01, 8'h40);
        rd(8'h11, 8'h50);
        chk(ch_enable, 8'h23);
        rd(8'h60, 8'he0);
        // Short comparator pulse stays below the filter
        wclk(1);
        open_load_pin <= 8'h04;
        wclk(OL_N / 2);
        open_load_pin <= 8'h00;
        wclk(5);
        rd(8'h11, 8'h50);
        open_load_pin <= 8'h06;
        wclk(OL_N + 8);
        open_load_pin <= 8'h00;
        wclk(2);
        rd(8'h01, 8'h40);
        u_spi_host_model.frame(8'h11, 8, rx);
        // Seven clocks: refused, so no read-to-clear
        u_spi_host_model.frame(8'h02, 7, rx);
        u_spi_host_model.frame(8'h11, 8, rx);
        chk(rx, 8'h52);
        u_spi_host_model.frame(8'h02, 8, rx);
        chk(rx, 8'h50);
        end_of_test();
    end
endmodule // relay_diag_bank_bench
